/* File: inc/mpd_defs.svh */
// Constants of the main-board memory decode and parity block.
// Assumes inclusion by bare name from the package file; design files see it through that include.
`ifndef MPD_DEFS_SVH
`define MPD_DEFS_SVH

// ==========================================================
// Geometry
`define MPD_BANKS 4
`define MPD_BANK_AW 16
`define MPD_DATA_W 8
`define MPD_ADDR_W 20
`define MPD_HI_W 10

// ==========================================================
// Address map, in 1 Kbyte units of the high address bits
`define MPD_DRAM_TOP_SMALL 10'h080
`define MPD_DRAM_TOP_LARGE 10'h100
`define MPD_EXP_BASE 10'h3a0
`define MPD_FW_BASE 10'h3e0
`define MPD_ROM0_BASE 10'h3f0
`define MPD_SOCKET_KB 5'h10

// ==========================================================
// Timing, refresh and parity
`define MPD_SLOW_WAITS 1'b1
`define MPD_REFRESH_CHAN 2'h0
`define MPD_PARITY_ODD 1'b1

`endif

/* File: inc/mpd_pkg.sv */
// Types shared by the memory decode block, its checker and its bench models.
// Assumes mpd_defs.svh on the include path.
`include "mpd_defs.svh"

package mpd_pkg;

    // ==========================================================
    // Bus cycle from processor or DMA master
    typedef struct packed {
        logic valid;
        logic write;
        logic dma;
        logic [1:0] chan;
        logic refresh;
        logic [`MPD_ADDR_W-1:0] addr;
        logic [`MPD_DATA_W-1:0] wdata;
    } mpd_req_t;

    // Board link straps, raw from the pins
    typedef struct packed {
        logic [1:0] rom0_size;
        logic [1:0] rom1_size;
        logic rom1_ram;
        logic large_map;
        logic slow_en;
        logic [`MPD_HI_W-1:0] slow_range;
    } mpd_strap_t;

    // Device selects
    typedef struct packed {
        logic dram;
        logic rom0;
        logic rom1;
        logic offboard;
    } mpd_sel_t;

    typedef enum logic [1:0] {
        MPD_IDLE = 2'b00,
        MPD_HOLD = 2'b01,
        MPD_DONE = 2'b10
    } mpd_state_t;

endpackage : mpd_pkg

/* File: rtl/mpd_decode.sv */
// Main-board memory decoder with parity DRAM, ROM selects and refresh.
// Assumes bus masters on clk; link straps are asynchronous pins.
`timescale 1ns/1ps

// Functional notes
// - DRAM holds up to four banks of 64K nine-bit locations.
// - Ninth bit of each location is parity over its eight data bits.
// - Odd bit errors on read back raise the non-maskable interrupt.
// - Refresh comes only from the one DMA channel reserved for it.
// - Each refresh cycle drives the bus refresh strobe for all memory.
// - One wait state may be added to any chosen 1 Kbyte range.
// - As delivered, processor memory cycles get no wait state.
// - At most 256 Kbytes DRAM and 32 Kbytes ROM on board.
// - E8000 up goes off board; firmware spans F8000 to FFFFF.
// - Each ROM socket decodes 2, 4, 8 or 16 Kbytes per links.
// - With link set, second socket is static RAM and takes writes.
// - Decoding looks only at address bits 10 to 19.
// - Off-board memory starts above 128K or 256K per variant.
// - Wait count loads a down counter early; cycle held until expiry.
module mpd_decode
    import mpd_pkg::*;
#(
    parameter int BANKS = `MPD_BANKS,
    parameter int BANK_AW = `MPD_BANK_AW
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire mpd_req_t req,
    output logic req_ready,
    output logic [`MPD_DATA_W-1:0] rd_data,
    input wire logic [`MPD_DATA_W-1:0] ext_rd_data,
    output mpd_sel_t dev_sel,
    output logic ext_we,
    output logic [`MPD_DATA_W-1:0] ext_wdata,
    output logic bus_refresh_strobe_n,
    output logic nmi,
    input wire logic nmi_ack,
    input wire mpd_strap_t straps
);

    localparam int AW = BANK_AW + $clog2(BANKS);

    // ==========================================================
    // Strap synchroniser; only the second stage is read
    mpd_strap_t strap_s1_r;
    mpd_strap_t strap_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strap_s1_r <= '0;
            strap_r <= '0;
        end else begin
            strap_s1_r <= straps;
            strap_r <= strap_s1_r;
        end
    end

    // ==========================================================
    // Address decode on the high bits only
    wire [`MPD_HI_W-1:0] high_address_bits =
        req.addr[`MPD_ADDR_W-1:`MPD_ADDR_W-`MPD_HI_W];
    wire [`MPD_HI_W-1:0] dram_top = strap_r.large_map ?
        `MPD_DRAM_TOP_LARGE : `MPD_DRAM_TOP_SMALL;
    wire hit_dram = high_address_bits < dram_top;
    wire hit_fw = high_address_bits >= `MPD_FW_BASE;
    wire hit_rom0_win = high_address_bits >= `MPD_ROM0_BASE;
    wire [4:0] win_kb = {1'b0, high_address_bits[3:0]};
    wire [4:0] rom0_kb = 5'h02 << strap_r.rom0_size;
    wire [4:0] rom1_kb = 5'h02 << strap_r.rom1_size;
    // Parts sit at the top of their 16K window, as a small EPROM would
    wire hit_rom0 = hit_fw && hit_rom0_win &&
        (win_kb >= (`MPD_SOCKET_KB - rom0_kb));
    wire hit_rom1 = hit_fw && !hit_rom0_win &&
        (win_kb >= (`MPD_SOCKET_KB - rom1_kb));
    // Unfilled firmware space and E8000 upward fall to the bus
    wire hit_off = !hit_dram && !hit_rom0 && !hit_rom1;

    wire is_refresh = req.refresh && req.dma &&
        (req.chan == `MPD_REFRESH_CHAN);
    wire slow_hit = strap_r.slow_en &&
        (high_address_bits == strap_r.slow_range);
    wire wait_load = slow_hit ? `MPD_SLOW_WAITS : 1'b0;

    mpd_sel_t sel_nxt;
    always_comb begin
        sel_nxt = '0;
        if (!is_refresh) begin
            sel_nxt.dram = hit_dram;
            sel_nxt.rom0 = hit_rom0;
            sel_nxt.rom1 = hit_rom1;
            sel_nxt.offboard = hit_off;
        end
    end

    // ==========================================================
    // Cycle sequencer
    mpd_state_t state_r;
    mpd_state_t state_nxt;
    logic wait_cnt_r;
    logic wr_r;
    logic refresh_r;
    mpd_sel_t sel_r;

    wire accept = (state_r == MPD_IDLE) && req.valid;
    wire hold_end = (state_r == MPD_HOLD) && (wait_cnt_r == 1'b0);

    always_comb begin
        unique case (state_r)
            MPD_IDLE: state_nxt = req.valid ? MPD_HOLD : MPD_IDLE;
            MPD_HOLD: state_nxt = hold_end ? MPD_DONE : MPD_HOLD;
            MPD_DONE: state_nxt = MPD_IDLE;
            default: state_nxt = MPD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= MPD_IDLE;
            wait_cnt_r <= 1'b0;
            wr_r <= 1'b0;
            refresh_r <= 1'b0;
            sel_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (accept) begin
                wait_cnt_r <= wait_load;
                wr_r <= req.write;
                refresh_r <= is_refresh;
                sel_r <= sel_nxt;
            end else if (state_r == MPD_HOLD && wait_cnt_r) begin
                wait_cnt_r <= 1'b0;
            end else if (state_r == MPD_DONE) begin
                sel_r <= '0;
                refresh_r <= 1'b0;
            end
        end
    end

    assign req_ready = (state_r == MPD_DONE);
    assign dev_sel = sel_r;

    // ==========================================================
    // Parity array
    wire [`MPD_DATA_W:0] dram_q;
    wire par_gen = (^req.wdata) ^ `MPD_PARITY_ODD;
    wire dram_en = accept && sel_nxt.dram;
    wire [AW-1:0] dram_addr = req.addr[AW-1:0];

    mpd_dram #(
        .ADDR_W(AW),
        .WIDTH(`MPD_DATA_W + 1)
    ) u_dram (
        .clk(clk),
        .en(dram_en),
        .we(req.write),
        .addr(dram_addr),
        .wdata({par_gen, req.wdata}),
        .rdata(dram_q)
    );

    // Array read register holds until next read, so wait states are safe
    wire par_bad = ((^dram_q) != `MPD_PARITY_ODD);
    wire par_err = hold_end && sel_r.dram && !wr_r &&
        !refresh_r && par_bad;

    // ==========================================================
    // Read data, socket RAM writes, refresh strobe, interrupt
    logic [`MPD_DATA_W-1:0] rd_data_r;
    logic ext_we_r;
    logic [`MPD_DATA_W-1:0] ext_wdata_r;
    logic refresh_n_r;
    logic nmi_r;

    wire [`MPD_DATA_W-1:0] rd_data_nxt =
        sel_r.dram ? dram_q[`MPD_DATA_W-1:0] : ext_rd_data;
    // Socket two stays read-only unless its link makes it RAM
    wire ext_we_nxt = accept && req.write && !sel_nxt.dram &&
        (!sel_nxt.rom1 || strap_r.rom1_ram) &&
        !sel_nxt.rom0 && !is_refresh;
    wire refresh_n_nxt = !(accept ? is_refresh :
        (refresh_r && state_r == MPD_HOLD));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data_r <= '0;
            ext_we_r <= 1'b0;
            ext_wdata_r <= '0;
            refresh_n_r <= 1'b1;
            nmi_r <= 1'b0;
        end else begin
            if (hold_end && !wr_r) begin
                rd_data_r <= rd_data_nxt;
            end
            ext_we_r <= ext_we_nxt;
            if (accept) begin
                ext_wdata_r <= req.wdata;
            end
            refresh_n_r <= refresh_n_nxt;
            // Set wins over a same-cycle acknowledge
            nmi_r <= par_err | (nmi_r & ~nmi_ack);
        end
    end

    assign rd_data = rd_data_r;
    assign ext_we = ext_we_r;
    assign ext_wdata = ext_wdata_r;
    assign bus_refresh_strobe_n = refresh_n_r;
    assign nmi = nmi_r;

endmodule : mpd_decode

/* File: rtl/mpd_dram.sv */
// Parity-protected dynamic memory array, one word per location.
// Assumes one access per cycle; read data come out of a register.
`timescale 1ns/1ps

module mpd_dram #(
    parameter int ADDR_W = 18,
    parameter int WIDTH = 9
) (
    input wire logic clk,
    input wire logic en,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

    // ==========================================================
    // Array, no reset: contents are undefined at power up
    always_ff @(posedge clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
        if (en && !we) begin
            rdata <= mem[addr];
        end
    end

endmodule : mpd_dram

/* File: tb/mpd_far.sv */
// Far-side model: ROM and off-board bytes.
// Assumes one selected device per cycle.
`timescale 1ns/1ps
module mpd_far
    import mpd_pkg::*;
(
    input wire logic clk,
    input wire mpd_sel_t dev_sel,
    input wire logic ext_we,
    input wire logic [7:0] ext_wdata,
    output logic [7:0] ext_rd_data
);
    logic [7:0] store_r = 8'h00;
    logic [7:0] idle_r = 8'h00;
    // Idle bus toggles so stale data never match
    always_ff @(posedge clk) begin
        idle_r <= ~idle_r;
        if (ext_we) begin
            store_r <= ext_wdata;
        end
    end
    assign ext_rd_data = dev_sel.rom0 ? 8'hc3 :
        (dev_sel.rom1 | dev_sel.offboard) ? store_r : idle_r;
endmodule : mpd_far

/* File: tb/mpd_props.sv */
// Checker for the memory decode block.
// Assumes it is bound onto mpd_decode.
`timescale 1ns/1ps
module mpd_props
    import mpd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire mpd_req_t req,
    input wire logic req_ready,
    input wire mpd_sel_t dev_sel,
    input wire logic ext_we,
    input wire logic bus_refresh_strobe_n,
    input wire logic nmi,
    input wire logic nmi_ack,
    input wire mpd_strap_t straps
);
    // ====
    // Cycle relations
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic hit = straps.slow_en && req.addr[19:10] == straps.slow_range;
    a_ready_pulse: assert property (req_ready |=> !req_ready)
        else $error("ready too long");
    a_fast_cycle: assert property ($rose(|dev_sel) && !hit |=> req_ready)
        else $error("unexpected wait");
    a_slow_cycle: assert property ($rose(|dev_sel) && hit
        |=> !req_ready ##1 req_ready)
        else $error("wait state wrong");
    a_strobe_walk: assert property ($fell(bus_refresh_strobe_n)
        |-> dev_sel == '0 ##[1:2] (req_ready && !bus_refresh_strobe_n))
        else $error("refresh strobe wrong");
    a_strobe_cause: assert property ($fell(bus_refresh_strobe_n)
        |-> $past(req.dma && req.refresh && req.chan == 2'h0))
        else $error("strobe without refresh");
    a_refresh_quiet: assert property (!bus_refresh_strobe_n && !nmi
        |=> !nmi)
        else $error("nmi in refresh");
    a_nmi_sticky: assert property (nmi && !nmi_ack |=> nmi)
        else $error("nmi dropped");
    a_nmi_origin: assert property ($rose(nmi)
        |-> req_ready && dev_sel.dram && !req.write)
        else $error("nmi without read");
    a_ext_write: assert property (ext_we
        |-> (dev_sel.offboard || dev_sel.rom1) ##1 !ext_we)
        else $error("bad external write");
    a_sel_single: assert property ($onehot0(dev_sel))
        else $error("several selects");
    c_refresh: cover property ($fell(bus_refresh_strobe_n));
    c_slow: cover property ($rose(|dev_sel) && hit);
    c_ext_we: cover property (ext_we);
endmodule : mpd_props

bind mpd_decode mpd_props u_props (.*);

/* File: tb/tb_top.sv */
// Self-checking bench for the memory decode block.
// Assumes the far-side model answers external reads.
`timescale 1ns/1ps
module tb_top import mpd_pkg::*; ;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic nmi_ack = 1'b0;
    mpd_req_t req = '0;
    mpd_strap_t straps = '0;
    logic req_ready, ext_we, strobe_n, nmi, we_got, str_got;
    logic [7:0] rd_data, ext_rd_data, ext_wdata;
    mpd_sel_t dev_sel, sel_got;
    int fails = 0;
    int comparisons = 0;
    int lat;
    mpd_decode dut (.clk(clk), .rst_b(rst_b), .req(req),
        .req_ready(req_ready), .rd_data(rd_data), .ext_rd_data(ext_rd_data),
        .dev_sel(dev_sel), .ext_we(ext_we), .ext_wdata(ext_wdata),
        .bus_refresh_strobe_n(strobe_n), .nmi(nmi), .nmi_ack(nmi_ack),
        .straps(straps));
    mpd_far far (.clk(clk), .dev_sel(dev_sel), .ext_we(ext_we),
        .ext_wdata(ext_wdata), .ext_rd_data(ext_rd_data));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    // Holds the request until ready, as the bus masters do
    task automatic cyc(input logic w, d, rf, input logic [1:0] ch,
        input logic [19:0] a, input logic [7:0] wd);
        @(posedge clk);
        req <= '{1'b1, w, d, ch, rf, a, wd};
        lat = 0;
        we_got = 1'b0;
        str_got = 1'b1;
        do begin
            @(posedge clk);
            #1;
            lat++;
            we_got |= ext_we;
            str_got &= strobe_n;
            sel_got = dev_sel;
        end while (req_ready !== 1'b1 && lat < 20);
        if (lat >= 20) begin
            fails++;
            print_verdict();
        end
        @(posedge clk);
        req.valid <= 1'b0;
    endtask : cyc
    task automatic strap(input mpd_strap_t s);
        @(posedge clk);
        straps <= s;
        repeat (3) @(posedge clk);
    endtask : strap
    task automatic t_dram;
        cyc(1, 0, 0, 0, 20'h1fffe, 8'h5a);
        chk({4'h0, sel_got}, 8'h08);
        chk(8'(lat), 8'h02);
        cyc(0, 0, 0, 0, 20'h1fffe, 8'h00);
        chk(rd_data, 8'h5a);
        chk({7'h0, nmi}, 8'h00);
        $display("dram done");
    endtask : t_dram
    task automatic t_map;
        logic [19:0] a[7] = '{20'h20000, 20'he8000, 20'hff800, 20'hfc000,
            20'h20000, 20'h3ffff, 20'h40000};
        logic [7:0] e[7] = '{8'h01, 8'h01, 8'h04, 8'h01, 8'h08, 8'h08, 8'h01};
        mpd_strap_t s = '0;
        for (int i = 0; i < 7; i++) begin
            if (i == 4) begin
                s.large_map = 1'b1;
                strap(s);
            end
            // Writes only: unwritten DRAM reads back unknown parity
            cyc(1, 0, 0, 0, a[i], 8'h00);
            chk({4'h0, sel_got}, e[i]);
        end
        $display("map done");
    endtask : t_map
    task automatic t_rom;
        mpd_strap_t s = '0;
        s.rom1_size = 2'h3;
        strap(s);
        cyc(1, 0, 0, 0, 20'hf8000, 8'h77);
        chk({7'h0, we_got}, 8'h00);
        s.rom1_ram = 1'b1;
        strap(s);
        cyc(1, 0, 0, 0, 20'hf8000, 8'h77);
        chk({7'h0, we_got}, 8'h01);
        cyc(0, 0, 0, 0, 20'hf8000, 8'h00);
        chk(rd_data, 8'h77);
        for (int z = 0; z < 4; z++) begin
            s.rom0_size = 2'(z);
            strap(s);
            cyc(1, 0, 0, 0, 20'(21'h100000 - (21'h800 << z)), 8'h11);
            chk({3'h0, we_got, sel_got}, 8'h04);
            cyc(0, 0, 0, 0, 20'(21'h0ffbff - (21'h800 << z)), 8'h00);
            chk({4'h0, sel_got}, z < 3 ? 8'h01 : 8'h02);
        end
        chk(rd_data, 8'h77);
        $display("rom done");
    endtask : t_rom
    task automatic t_wait;
        logic [19:0] a[4] = '{20'h013ff, 20'h01400, 20'h017ff, 20'h01800};
        logic [7:0] e[4] = '{8'h02, 8'h03, 8'h03, 8'h02};
        mpd_strap_t s = '0;
        s.slow_en = 1'b1;
        s.slow_range = 10'h005;
        strap(s);
        for (int i = 0; i < 4; i++) begin
            cyc(1, 0, 0, 0, a[i], 8'h00);
            chk(8'(lat), e[i]);
        end
        $display("wait done");
    endtask : t_wait
    task automatic t_refresh;
        cyc(0, 1, 1, 2'h0, 20'h00000, 8'h00);
        chk({3'h0, str_got, sel_got}, 8'h00);
        chk(8'(lat), 8'h02);
        cyc(1, 1, 1, 2'h1, 20'h00000, 8'h00);
        chk({3'h0, str_got, sel_got}, 8'h18);
        $display("refresh done");
    endtask : t_refresh
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({6'h0, strobe_n, nmi}, 8'h02);
        t_dram();
        t_map();
        t_rom();
        t_wait();
        t_refresh();
        print_verdict();
    end
endmodule : tb_top
